//--- design/tfc_xlate_check.v
// translation entry buffer for one translator with permission checks
// assumes the tablewalker or software presents entries on the fill port
// and the pipeline presents one lookup per cycle with its access kind
`timescale 1ns/1ps
`include "tfc_regs.vh"

module tfc_xlate_check #(
    parameter ENTRIES = `TFC_ENTRIES,
    parameter IDX_W = `TFC_IDX_W,
    parameter IS_INSTR = 0
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // entry fill
    input wire fill_en,
    input wire [IDX_W-1:0] fill_idx,
    input wire [63:0] fill_tag,
    input wire [63:0] fill_data,
    input wire fill_real,
    output wire fill_refused,
    // entry readback
    input wire [IDX_W-1:0] rd_idx,
    output reg [63:0] rd_tag,
    output reg [63:0] rd_data,
    // lookup request
    input wire look_en,
    input wire [63:0] look_va,
    input wire [`TFC_CTX_W-1:0] look_ctx,
    input wire look_real,
    input wire look_write,
    input wire look_nofault_asi,
    input wire look_little,
    input wire supervisor_state_flag,
    // lookup result
    output reg res_valid,
    output reg res_hit,
    output reg [39:0] res_pa,
    output reg res_little,
    output reg res_side_effect,
    output reg res_no_merge,
    output reg res_phys_cache_ok,
    output reg inst_noload_fault_trap,
    output reg data_noload_fault_trap,
    output reg inst_priv_fault_trap,
    output reg data_priv_fault_trap,
    output reg write_protect_trap
);

////////////////////////////////////////////////////////////////////////
// storage

reg [ENTRIES-1:0] ent_valid;
reg [ENTRIES-1:0] ent_real;
reg [ENTRIES-1:0] ent_nfo;
reg [ENTRIES-1:0] ent_ibo;
reg [ENTRIES-1:0] ent_side;
reg [ENTRIES-1:0] ent_cp;
reg [ENTRIES-1:0] ent_priv;
reg [ENTRIES-1:0] ent_wr;
reg [ENTRIES-1:0] ent_par;
reg [`TFC_CTX_W-1:0] ent_ctx [0:ENTRIES-1];
reg [41:0] ent_vtag [0:ENTRIES-1];
reg [`TFC_PA_W-1:0] ent_pa [0:ENTRIES-1];
reg [3:0] ent_size [0:ENTRIES-1];

////////////////////////////////////////////////////////////////////////
// helpers

function size_ok;
    input [3:0] code;
    begin
        size_ok = (code == `TFC_SZ_8K) || (code == `TFC_SZ_64K) ||
                  (code == `TFC_SZ_4M) || (code == `TFC_SZ_256M);
    end
endfunction

// mask of virtual address bits 63:13 compared for a page size
function [50:0] va_mask;
    input [3:0] code;
    integer k;
    integer lo;
    begin
        case (code)
            `TFC_SZ_64K: lo = `TFC_OFF_64K;
            `TFC_SZ_4M: lo = `TFC_OFF_4M;
            `TFC_SZ_256M: lo = `TFC_OFF_256M;
            default: lo = `TFC_OFF_8K;
        endcase
        for (k = 0; k < 51; k = k + 1) begin
            va_mask[k] = ((k + `TFC_OFF_8K) >= lo);
        end
    end
endfunction

// 48-bit space: upper bits must copy bit 47
function va_in_range;
    input [63:0] va;
    begin
        va_in_range = (va[63:`TFC_VA_IMPL_MSB] == {17{1'b0}}) ||
                      (va[63:`TFC_VA_IMPL_MSB] == {17{1'b1}});
    end
endfunction

////////////////////////////////////////////////////////////////////////
// fill

wire fill_size_ok = size_ok(fill_data[`TFC_D_SZ_HI:`TFC_D_SZ_LO]);
// nonzero real page bits above 39
wire fill_rpn_bad = |fill_data[`TFC_D_RPN_ZHI:`TFC_D_RPN_ZLO];
// no executable-less entry in the instruction buffer
wire fill_no_exec = (IS_INSTR != 0) && !fill_data[`TFC_D_EXEC];
assign fill_refused = fill_en && (!fill_size_ok || fill_rpn_bad || fill_no_exec);

// parity over the stored data fields except valid, returned on bit 61
wire fill_par = ^{fill_data[`TFC_D_PA_HI:`TFC_D_PA_LO], fill_data[`TFC_D_IBO],
                  fill_data[`TFC_D_SIDE], fill_data[`TFC_D_CP], fill_data[`TFC_D_PRIV],
                  fill_data[`TFC_D_WR], fill_data[`TFC_D_NFO],
                  fill_data[`TFC_D_SZ_HI:`TFC_D_SZ_LO]};

genvar g;
generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : gen_ent
        always @(posedge clk) begin
            if (sys_rst) begin
                ent_valid[g] <= 1'b0;
                ent_real[g] <= 1'b0;
                ent_nfo[g] <= 1'b0;
                ent_ibo[g] <= 1'b0;
                ent_side[g] <= 1'b0;
                ent_cp[g] <= 1'b0;
                ent_priv[g] <= 1'b0;
                ent_wr[g] <= 1'b0;
                ent_par[g] <= 1'b0;
                ent_ctx[g] <= {`TFC_CTX_W{1'b0}};
                ent_vtag[g] <= 42'h0;
                ent_pa[g] <= {`TFC_PA_W{1'b0}};
                ent_size[g] <= `TFC_SZ_8K;
            end else if (fill_en && fill_idx == g) begin
                // a refused fill still claims the slot so a stale entry cannot survive
                // refused fill leaves the slot invalid
                ent_valid[g] <= fill_data[`TFC_D_VALID] && !fill_refused;
                ent_real[g] <= fill_real;
                ent_nfo[g] <= fill_data[`TFC_D_NFO];
                // instruction buffer keeps these for readback
                ent_ibo[g] <= fill_data[`TFC_D_IBO];
                ent_side[g] <= fill_data[`TFC_D_SIDE];
                ent_wr[g] <= fill_data[`TFC_D_WR];
                // hint bit dropped, only phys bit stored
                ent_cp[g] <= fill_data[`TFC_D_CP];
                ent_priv[g] <= fill_data[`TFC_D_PRIV];
                ent_par[g] <= fill_par;
                // context field, reserved tag bits dropped
                ent_ctx[g] <= fill_tag[`TFC_TAG_CTX_HI:`TFC_TAG_CTX_LO];
                // page tag from tag bits 41:0
                ent_vtag[g] <= fill_tag[`TFC_TAG_VA_HI:`TFC_TAG_VA_LO];
                ent_pa[g] <= fill_data[`TFC_D_PA_HI:`TFC_D_PA_LO];
                ent_size[g] <= fill_data[`TFC_D_SZ_HI:`TFC_D_SZ_LO];
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// readback

reg [63:0] next_rd_tag;
reg [63:0] next_rd_data;
always @* begin
    next_rd_tag = 64'h0;
    next_rd_tag[`TFC_TAG_CTX_HI:`TFC_TAG_CTX_LO] = ent_ctx[rd_idx];
    next_rd_tag[`TFC_TAG_VA_HI:`TFC_TAG_VA_LO] = ent_vtag[rd_idx];
    // hint and exec bits, spares and high real page bits stay zero
    next_rd_data = 64'h0;
    next_rd_data[`TFC_D_VALID] = ent_valid[rd_idx];
    next_rd_data[`TFC_D_NFO] = ent_nfo[rd_idx];
    // bit 61 returns the parity of the stored data fields other than valid
    next_rd_data[`TFC_D_PARITY] = ent_par[rd_idx];
    next_rd_data[`TFC_D_PA_HI:`TFC_D_PA_LO] = ent_pa[rd_idx];
    next_rd_data[`TFC_D_IBO] = ent_ibo[rd_idx];
    next_rd_data[`TFC_D_SIDE] = ent_side[rd_idx];
    next_rd_data[`TFC_D_CP] = ent_cp[rd_idx];
    next_rd_data[`TFC_D_PRIV] = ent_priv[rd_idx];
    next_rd_data[`TFC_D_WR] = ent_wr[rd_idx];
    next_rd_data[`TFC_D_SZ_HI:`TFC_D_SZ_LO] = ent_size[rd_idx];
end

// readback is registered, one cycle behind rd_idx
always @(posedge clk) begin
    if (sys_rst) begin
        rd_tag <= 64'h0;
        rd_data <= 64'h0;
    end else begin
        rd_tag <= next_rd_tag;
        rd_data <= next_rd_data;
    end
end

////////////////////////////////////////////////////////////////////////
// lookup

// tag bits 41:0 map to va 63:22; the stored tag is widened with va 21:13 zero
// va 21:13 are never compared, the tag does not hold them
localparam [50:0] TAG_CMP_MASK = {{42{1'b1}}, 9'h0};
reg [ENTRIES-1:0] hit_vec;
reg [IDX_W-1:0] hit_idx;
reg ent_ok;
reg ctx_ok;
reg [50:0] va_diff;
integer i;
// a lookup in the same cycle as a fill sees the old entry: there is no bypass
always @* begin
    hit_vec = {ENTRIES{1'b0}};
    hit_idx = {IDX_W{1'b0}};
    ent_ok = 1'b0;
    ctx_ok = 1'b0;
    va_diff = 51'h0;
    for (i = 0; i < ENTRIES; i = i + 1) begin
        // valid gate, reserved sizes never hit
        ent_ok = ent_valid[i] && size_ok(ent_size[i]);
        // real entries answer real lookups only and skip the context
        ctx_ok = (ent_real[i] == look_real) && (ent_real[i] || ent_ctx[i] == look_ctx);
        va_diff = ({ent_vtag[i], 9'h0} ^ look_va[63:13]) & va_mask(ent_size[i]) & TAG_CMP_MASK;
        // addresses in the hole never hit
        hit_vec[i] = ent_ok && ctx_ok && (va_diff == 51'h0) && va_in_range(look_va);
    end
    // lowest slot wins if software loads a duplicate, so one entry answers
    for (i = ENTRIES - 1; i >= 0; i = i - 1) begin
        if (hit_vec[i]) begin
            hit_idx = i[IDX_W-1:0];
        end
    end
end

// physical address: page bits from entry, offset bits from va
wire [50:0] hmask = va_mask(ent_size[hit_idx]);
wire [26:0] pa_page = (ent_pa[hit_idx] & hmask[26:0]) | (look_va[39:13] & ~hmask[26:0]);
wire any_hit = |hit_vec;

// next result values, registered below
reg next_little;
reg next_side_effect;
reg next_inst_nfo;
reg next_data_nfo;
reg next_inst_priv;
reg next_data_priv;
reg next_write_prot;
// traps are gated by a hit so a miss never raises a fault
wire look_hit = look_en && any_hit;
// privilege applies to real and virtual hits alike
wire priv_viol = look_hit && ent_priv[hit_idx] && !supervisor_state_flag;

always @* begin
    next_little = look_little;
    next_side_effect = 1'b0;
    next_inst_nfo = 1'b0;
    next_data_nfo = 1'b0;
    next_inst_priv = 1'b0;
    next_data_priv = 1'b0;
    next_write_prot = 1'b0;
    if (IS_INSTR != 0) begin
        // order, side-effect, writable ignored on fetch
        next_little = look_little;
        next_side_effect = 1'b0;
        next_inst_nfo = look_hit && ent_nfo[hit_idx];
        next_inst_priv = priv_viol;
    end else begin
        next_little = look_little ^ ent_ibo[hit_idx];
        // ordering and no merge only for noncacheable side-effect pages
        next_side_effect = ent_side[hit_idx] && !ent_cp[hit_idx];
        next_data_nfo = look_hit && ent_nfo[hit_idx] && (look_write || !look_nofault_asi);
        next_data_priv = priv_viol;
        next_write_prot = look_hit && look_write && !ent_wr[hit_idx];
    end
end

// results stand for one cycle, recomputed on every edge
always @(posedge clk) begin
    if (sys_rst) begin
        res_valid <= 1'b0;
        res_hit <= 1'b0;
        res_pa <= 40'h0;
        res_little <= 1'b0;
        res_side_effect <= 1'b0;
        res_no_merge <= 1'b0;
        res_phys_cache_ok <= 1'b0;
        inst_noload_fault_trap <= 1'b0;
        data_noload_fault_trap <= 1'b0;
        inst_priv_fault_trap <= 1'b0;
        data_priv_fault_trap <= 1'b0;
        write_protect_trap <= 1'b0;
    end else begin
        res_valid <= look_en;
        res_hit <= look_hit;
        res_pa <= {pa_page, look_va[12:0]};
        res_little <= next_little;
        // one flag drives both the ordering and the merge blocker
        res_side_effect <= next_side_effect;
        res_no_merge <= next_side_effect;
        inst_noload_fault_trap <= next_inst_nfo;
        data_noload_fault_trap <= next_data_nfo;
        inst_priv_fault_trap <= next_inst_priv;
        data_priv_fault_trap <= next_data_priv;
        write_protect_trap <= next_write_prot;
        res_phys_cache_ok <= ent_cp[hit_idx];
    end
end

endmodule

//--- design/tfc_regs.vh
// field positions, encodings and sizes for translation entry words
// assumes it is included by the translation check module only
`ifndef TFC_REGS_VH
`define TFC_REGS_VH

`define TFC_TAG_CTX_HI 60
`define TFC_TAG_CTX_LO 48
`define TFC_TAG_VA_HI 41
`define TFC_TAG_VA_LO 0
`define TFC_VA_TAG_HI 63
`define TFC_VA_TAG_LO 22
`define TFC_VA_IMPL_MSB 47

`define TFC_D_VALID 63
`define TFC_D_NFO 62
`define TFC_D_PARITY 61
`define TFC_D_PA_HI 39
`define TFC_D_PA_LO 13
`define TFC_D_RPN_HI 55
`define TFC_D_RPN_ZHI 55
`define TFC_D_RPN_ZLO 40
`define TFC_D_IBO 12
`define TFC_D_SIDE 11
`define TFC_D_CP 10
`define TFC_D_CV 9
`define TFC_D_PRIV 8
`define TFC_D_EXEC 7
`define TFC_D_WR 6
`define TFC_D_SZ_HI 3
`define TFC_D_SZ_LO 0

`define TFC_SZ_8K 4'h0
`define TFC_SZ_64K 4'h1
`define TFC_SZ_4M 4'h3
`define TFC_SZ_256M 4'h5

// first virtual address bit above the page offset for each size
`define TFC_OFF_8K 13
`define TFC_OFF_64K 16
`define TFC_OFF_4M 22
`define TFC_OFF_256M 28

`define TFC_CTX_W 13
`define TFC_PA_W 27
`define TFC_ENTRIES 8
`define TFC_IDX_W 3

`endif

//--- tb/tfc_xlate_chk.sv
// port checker for the translation entry buffer, data side
// assumes it is bound into tfc_xlate_check and sees one clock domain
`timescale 1ns/1ps
module tfc_xlate_chk #(
    parameter ENTRIES = 8,
    parameter IDX_W = 3,
    parameter IS_INSTR = 0
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // fill and lookup inputs
    input wire fill_en,
    input wire [63:0] fill_data,
    input wire fill_refused,
    input wire look_en,
    input wire [63:0] look_va,
    input wire look_write,
    input wire look_nofault_asi,
    input wire supervisor_state_flag,
    // results
    input wire res_valid,
    input wire res_hit,
    input wire res_side_effect,
    input wire res_no_merge,
    input wire res_phys_cache_ok,
    input wire data_noload_fault_trap,
    input wire data_priv_fault_trap,
    input wire write_protect_trap
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [3:0] sz = fill_data[3:0];
    wire sz_ok = (sz == 4'h0) || (sz == 4'h1) || (sz == 4'h3) || (sz == 4'h5);
    wire rpn_hi = |fill_data[55:40];
    wire va_hole = look_va[63:47] != {17{look_va[47]}};
    wire any_trap = data_noload_fault_trap || data_priv_fault_trap || write_protect_trap;
    ////////////////////////////////////////////////////////////////////////
    a_size_refused: assert property (fill_en && !sz_ok |-> fill_refused)
        else $error("reserved size fill not refused");
    a_rpn_refused: assert property (fill_en && rpn_hi |-> fill_refused)
        else $error("high real page bits fill not refused");
    a_legal_fill_taken: assert property (fill_en && sz_ok && !rpn_hi |-> !fill_refused)
        else $error("legal fill refused");
    a_va_hole_miss: assert property (look_en && va_hole |-> ##1 (res_valid && !res_hit))
        else $error("lookup outside implemented space hit");
    a_priv_super_ok: assert property (look_en && supervisor_state_flag |=> !data_priv_fault_trap)
        else $error("privilege trap in supervisor state");
    a_wprot_read_ok: assert property (look_en && !look_write |=> res_valid && !write_protect_trap)
        else $error("write protect trap on read");
    a_nofault_load_ok: assert property (look_en && look_nofault_asi && !look_write
        |=> !data_noload_fault_trap)
        else $error("no-fault load trapped");
    a_trap_on_hit: assert property (any_trap |-> res_valid && res_hit && $past(look_en))
        else $error("trap without a hit");
    a_side_no_merge: assert property (res_valid && res_hit |-> res_side_effect == res_no_merge)
        else $error("ordering and merge flags disagree");
    a_side_uncached: assert property (res_valid && res_hit && res_side_effect
        |-> res_no_merge && !res_phys_cache_ok)
        else $error("side-effect ordering on a first-level cacheable page");
    c_hit: cover property (res_valid && res_hit);
    c_wprot: cover property (write_protect_trap);
    c_refused: cover property (fill_en && fill_refused);
endmodule
bind tfc_xlate_check tfc_xlate_chk #(.ENTRIES(ENTRIES), .IDX_W(IDX_W), .IS_INSTR(IS_INSTR)) chk_u (
    .clk(clk), .sys_rst(sys_rst), .fill_en(fill_en), .fill_data(fill_data),
    .fill_refused(fill_refused), .look_en(look_en), .look_va(look_va), .look_write(look_write),
    .look_nofault_asi(look_nofault_asi), .supervisor_state_flag(supervisor_state_flag),
    .res_valid(res_valid), .res_hit(res_hit), .res_side_effect(res_side_effect),
    .res_no_merge(res_no_merge), .res_phys_cache_ok(res_phys_cache_ok),
    .data_noload_fault_trap(data_noload_fault_trap),
    .data_priv_fault_trap(data_priv_fault_trap), .write_protect_trap(write_protect_trap));

//--- tb/tfc_pipe_model.sv
// load/store pipeline and tablewalker stand-in: fills entries, issues lookups
// assumes inputs change 1 ns after the rising edge, one request per task call
`timescale 1ns/1ps
module tfc_pipe_model (
    // clock and refusal flag
    input wire clk,
    input wire fill_refused,
    // entry fill
    output reg fill_en,
    output reg [2:0] fill_idx,
    output reg [63:0] fill_tag,
    output reg [63:0] fill_data,
    output reg fill_real,
    // lookup
    output reg look_en,
    output reg [63:0] look_va,
    output reg [12:0] look_ctx,
    output reg look_real,
    output reg look_write,
    output reg look_nofault_asi,
    output reg look_little,
    output reg supervisor_state_flag
);
    reg refused;
    initial begin
        {fill_en, fill_idx, fill_tag, fill_data, fill_real, refused} = 0;
        {look_en, look_va, look_ctx, look_real, look_write} = 0;
        {look_nofault_asi, look_little, supervisor_state_flag} = 0;
    end
    // caller keeps bits 55:40 clear except where a refusal is wanted
    task fill(input [2:0] i, input [63:0] t, input [63:0] d, input r);
        begin
            @(posedge clk);
            #1 {fill_en, fill_idx, fill_tag, fill_data, fill_real} = {1'b1, i, t, d, r};
            #1 refused = fill_refused;
            @(posedge clk);
            // released tag and data lines do not hold their last value
            #1 {fill_en, fill_tag, fill_data} = {1'b0, ~t, ~d};
        end
    endtask
    task look(input [63:0] va, input [12:0] cx, input [4:0] k);
        begin
            @(posedge clk);
            #1 {look_en, look_va, look_ctx} = {1'b1, va, cx};
            {look_real, look_write, look_nofault_asi, look_little, supervisor_state_flag} = k;
            @(posedge clk);
            #1 {look_en, look_va} = {1'b0, ~va};
        end
    endtask
endmodule

//--- tb/tb_tfc_xlate_check.sv
// self-checking bench for the data-side translation entry buffer
// assumes the partner model drives all fill and lookup inputs
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked = checked + 1; if ((gt) !== (ex)) begin \
    mismatches = mismatches + 1; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module tb_tfc_xlate_check;
    reg clk, sys_rst;
    reg [2:0] rd_idx;
    wire fill_en, fill_real, fill_refused, look_en, look_real, look_write, look_nofault_asi;
    wire look_little, supervisor_state_flag, res_valid, res_hit, res_little, res_side_effect;
    wire res_no_merge, res_phys_cache_ok, i_nfo, data_noload_fault_trap, i_priv;
    wire data_priv_fault_trap, write_protect_trap;
    wire [2:0] fill_idx;
    wire [63:0] fill_tag, fill_data, rd_tag, rd_data, look_va;
    wire [12:0] look_ctx;
    wire [39:0] res_pa;
    integer mismatches = 0, checked = 0, cycles = 0, k, off;
    localparam [63:0] VA = 64'h0000_1234_0000_0000;
    localparam [39:0] PA = 40'h12_3000_0000;
    // reserved tag bits set on purpose: they must be dropped
    localparam [63:0] TAG = {3'h7, 13'h0005, 6'h3f, VA[63:22]};
    tfc_xlate_check #(.IS_INSTR(0)) dut_u (.clk(clk), .sys_rst(sys_rst), .fill_en(fill_en),
        .fill_idx(fill_idx), .fill_tag(fill_tag), .fill_data(fill_data), .fill_real(fill_real),
        .fill_refused(fill_refused), .rd_idx(rd_idx), .rd_tag(rd_tag), .rd_data(rd_data),
        .look_en(look_en), .look_va(look_va), .look_ctx(look_ctx), .look_real(look_real),
        .look_write(look_write), .look_nofault_asi(look_nofault_asi), .look_little(look_little),
        .supervisor_state_flag(supervisor_state_flag), .res_valid(res_valid), .res_hit(res_hit),
        .res_pa(res_pa), .res_little(res_little), .res_side_effect(res_side_effect),
        .res_no_merge(res_no_merge), .res_phys_cache_ok(res_phys_cache_ok),
        .inst_noload_fault_trap(i_nfo), .data_noload_fault_trap(data_noload_fault_trap),
        .inst_priv_fault_trap(i_priv), .data_priv_fault_trap(data_priv_fault_trap),
        .write_protect_trap(write_protect_trap));
    tfc_pipe_model pm_u (.clk(clk), .fill_refused(fill_refused), .fill_en(fill_en),
        .fill_idx(fill_idx), .fill_tag(fill_tag), .fill_data(fill_data), .fill_real(fill_real),
        .look_en(look_en), .look_va(look_va), .look_ctx(look_ctx), .look_real(look_real),
        .look_write(look_write), .look_nofault_asi(look_nofault_asi), .look_little(look_little),
        .supervisor_state_flag(supervisor_state_flag));
    ////////////////////////////////////////////////////////////////////////
    // flags f: order, side, cp, cv, priv, exec, writable, spare 5:4
    function [63:0] mk(input [3:0] sz, input [8:0] f, input nfo);
        mk = {1'b1, nfo, 6'h00, 16'h0000, PA[39:13], f, sz};
    endfunction
    // k = {real, write, nofault, little, supervisor}; ex = {hit, little, side, cp, 3 traps}
    task tc(input [63:0] d, input rl, input [12:0] cx, input [4:0] kk, input [6:0] ex);
        begin
            pm_u.fill(3'h0, TAG, d, rl);
            pm_u.look(VA + 64'h100, cx, kk);
            if (ex[6])
                `CHK("result", {1'b1, ex}, {res_valid, res_hit, res_little, res_side_effect,
                    res_phys_cache_ok, data_noload_fault_trap, data_priv_fault_trap,
                    write_protect_trap})
            else
                `CHK("miss", 5'h10, {res_valid, res_hit, data_noload_fault_trap,
                    data_priv_fault_trap, write_protect_trap})
            `CHK("inst traps", 2'h0, {i_nfo, i_priv})
        end
    endtask
    task summarize;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    // ceiling well above the roughly 80 cycles the sequence needs
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            summarize;
        end
    end
    initial begin
        sys_rst = 1;
        rd_idx = 3'h0;
        repeat (5) @(posedge clk);
        #1 sys_rst = 0;
        // readback drops reserved, spare, hint and exec bits
        pm_u.fill(3'h1, {3'h7, 13'h0007, 6'h3f, VA[63:22]}, mk(4'h0, 9'h1ff, 1) | 64'h3f << 56, 0);
        rd_idx = 3'h1;
        @(posedge clk);
        #1 `CHK("rd_tag", {3'h0, 13'h0007, 6'h00, VA[63:22]}, rd_tag)
        `CHK("rd_data", mk(4'h0, 9'h1d4, 1), rd_data & ~(64'h1 << 61))
        // every legal size, offset taken from the lookup address
        for (k = 0; k < 4; k = k + 1) begin
            off = (k == 0) ? 13 : (k == 1) ? 16 : (k == 2) ? 22 : 28;
            pm_u.fill(3'h0, TAG, mk(k == 0 ? 4'h0 : 4'h1 + 4'(2 * (k - 1)), 9'h04c, 0), 0);
            pm_u.look(VA + (64'h1 << off) - 64'h8, 13'h0005, 5'h01);
            `CHK("hit", 2'h3, {res_hit, res_phys_cache_ok})
            `CHK("pa", PA | ((40'h1 << off) - 40'h8), res_pa)
        end
        tc(mk(4'h0, 9'h05c, 0), 0, 13'h0005, 5'h00, 7'h4a);
        tc(mk(4'h0, 9'h05c, 0), 0, 13'h0005, 5'h01, 7'h48);
        tc(mk(4'h0, 9'h048, 0), 0, 13'h0005, 5'h09, 7'h49);
        tc(mk(4'h0, 9'h04c, 1), 0, 13'h0005, 5'h01, 7'h4c);
        tc(mk(4'h0, 9'h04c, 1), 0, 13'h0005, 5'h05, 7'h48);
        tc(mk(4'h0, 9'h14c, 0), 0, 13'h0005, 5'h01, 7'h68);
        tc(mk(4'h0, 9'h14c, 0), 0, 13'h0005, 5'h03, 7'h48);
        tc(mk(4'h0, 9'h08c, 0), 0, 13'h0005, 5'h01, 7'h50);
        tc(mk(4'h0, 9'h04c, 0) & ~(64'h1 << 63), 0, 13'h0005, 5'h01, 7'h00);
        tc(mk(4'h0, 9'h04c, 0), 0, 13'h0006, 5'h01, 7'h00);
        tc(mk(4'h0, 9'h04c, 0), 1, 13'h0006, 5'h11, 7'h48);
        tc(mk(4'h2, 9'h04c, 0), 0, 13'h0005, 5'h01, 7'h00);
        `CHK("refused", 1'b1, pm_u.refused)
        tc(mk(4'h0, 9'h04c, 0) | 64'h1 << 40, 0, 13'h0005, 5'h01, 7'h00);
        `CHK("refused", 1'b1, pm_u.refused)
        pm_u.look(VA | 64'h1 << 47, 13'h0005, 5'h01);
        `CHK("hole", 2'h2, {res_valid, res_hit})
        summarize;
    end
endmodule
